// ---- src/ascd_pkg.sv ----
// Operation
// RULE_01: bit 29 picks temporal or spatial direct
// RULE_02: bits 28:27 select deblocking edge behaviour
// RULE_03: bits 25:24 pick arithmetic context table
// RULE_04: bits 21:16 are slice quantiser
// RULE_05: bits 11:8 signed beta strength offset
// RULE_06: bits 3:0 signed alpha strength offset
// RULE_07: start row and column in macroblocks
// RULE_08: builder keeps block index consistent
// RULE_09: phantom slice index is total plus one
// RULE_10: bit 7 enables alternative skip decoding
// RULE_11: bits 2:0 are valid bits minus one
// RULE_12: arithmetic-coded slices use value seven
// RULE_13: counter dword seeds first decrypted chunk
// RULE_14: raw length is true length plus one
// RULE_15: application pads to sixteen-byte chunk end
// RULE_16: bit vector start bit and packet count
// RULE_17: bit vector address, 4K aligned
// RULE_18: zero bit fetches packet, one skips
// RULE_19: four weight-128 masks forwarded as inline
// RULE_20: one slice per decode command
// RULE_21: start address plus offset locates first bit
// RULE_22: decode up to last non-zero byte only
// RULE_23: dword 1 bit 31 enables decryption
// RULE_24: parameters held until reset or next command
// RULE_25: slice kind encodings, bits 3:2 zero
// RULE_26: reserved fields written zero, ignored
package ascd_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DW1 = 8'h08;
    localparam logic [7:0] OFF_DW3 = 8'h0c;
    localparam logic [7:0] OFF_DW4 = 8'h10;
    localparam logic [7:0] OFF_DW5 = 8'h14;
    localparam logic [7:0] OFF_DW6 = 8'h18;
    localparam logic [7:0] OFF_DW7 = 8'h1c;
    localparam logic [7:0] OFF_DW8 = 8'h20;
    localparam logic [7:0] OFF_DW9 = 8'h24;
    localparam logic [7:0] OFF_DW10 = 8'h28;
    localparam logic [7:0] OFF_DW11 = 8'h2c;
    localparam logic [7:0] OFF_DW12 = 8'h30;
    localparam logic [7:0] OFF_DW13 = 8'h34;
    localparam logic [7:0] OFF_DW14 = 8'h38;
    localparam logic [7:0] OFF_DW15 = 8'h3c;
    localparam logic [7:0] OFF_ADDR = 8'h40;
    localparam logic [7:0] OFF_LEN = 8'h44;
    // field positions
    localparam int ENC_BIT = 31;
    localparam int DIRECT_BIT = 29;
    localparam int DBK_HI = 28;
    localparam int DBK_LO = 27;
    localparam int CTX_HI = 25;
    localparam int CTX_LO = 24;
    localparam int QP_HI = 21;
    localparam int QP_LO = 16;
    localparam int BETA_HI = 11;
    localparam int BETA_LO = 8;
    localparam int ALPHA_HI = 3;
    localparam int ALPHA_LO = 0;
    localparam int ROW_HI = 31;
    localparam int ROW_LO = 24;
    localparam int COL_HI = 23;
    localparam int COL_LO = 16;
    localparam int IDX_HI = 14;
    localparam int SKIP_BIT = 7;
    localparam int FBV_HI = 2;
    localparam int RAWLEN_HI = 22;
    localparam int VSTART_HI = 31;
    localparam int VSTART_LO = 29;
    localparam int PKTCNT_HI = 15;
    localparam int VADDR_HI = 28;
    localparam int KIND_HI = 3;
    localparam int PAGE_BITS = 12;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [2:0] FBV_ALL = 3'h7;
    // slice kinds
    localparam logic [3:0] KIND_P = 4'h0;
    localparam logic [3:0] KIND_B = 4'h1;
    localparam logic [3:0] KIND_I = 4'h2;
    typedef enum logic [1:0] {
        DBK_FILTER_ALL,
        DBK_OFF,
        DBK_SLICE_LOCAL,
        DBK_RESERVED
    } ascd_dbk_t;
    typedef enum logic [1:0] {
        KIND_PRED,
        KIND_BIDIR,
        KIND_INTRA,
        KIND_BAD
    } ascd_kind_t;
endpackage : ascd_pkg

// ---- src/ascd_slice_decode.sv ----
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module ascd_slice_decode (
    input wire logic core_clk, // core clock, 20 MHz
    input wire logic nrst, // async reset, active low
    input wire logic hsel, // ahb select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic [31:0] hrdata, // ahb read data
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response, always okay
    input wire logic engine_done, // engine finished slice
    output logic slice_go, // one-cycle start pulse to engine
    output logic direct_spatial, // 1 spatial, 0 temporal direct
    output logic [1:0] deblock_control, // raw deblock mode
    output logic internal_edge_filter_flag, // filter internal edges
    output logic deblock_params_used, // deblocking params read
    output logic cross_slice_unavail, // other slices unavailable
    output logic [1:0] arith_ctx_table_index, // context init table
    output logic [5:0] slice_quantizer, // slice_quantizer
    output logic signed [4:0] beta_strength_offset, // sign-extended offset
    output logic signed [4:0] alpha_strength_offset, // sign-extended offset
    output logic [7:0] start_row, // first mb row
    output logic [7:0] start_column, // first mb column
    output logic [14:0] start_block_index, // first mb linear address
    output logic alt_skip_decode, // alternative skip decode
    output logic [3:0] first_valid_count, // valid bits in first byte, 1..8
    output logic [31:0] first_bit_addr, // bit address of first mb bit
    output logic [31:0] last_byte_addr, // last decoded byte address
    output logic decrypt_enable, // counter-mode decrypt on
    output logic [31:0] aes_counter_seed, // counter for first chunk
    output logic [31:0] aes_chunk_addr, // 16-byte chunk with first byte
    output logic [22:0] raw_length, // true valid byte length
    output logic [2:0] vector_start_bit, // bit vector start bit
    output logic [15:0] packet_count, // total packets
    output logic [28:0] vector_addr, // bit vector surface address
    output logic vector_misaligned, // address not on 4K page
    output logic [31:0] unity_weight_mask_y_list0, // luma l0 weight 128
    output logic [31:0] unity_weight_mask_y_list1, // luma l1 weight 128
    output logic [31:0] unity_weight_mask_c_list0, // chroma l0 weight 128
    output logic [31:0] unity_weight_mask_c_list1, // chroma l1 weight 128
    output logic [1:0] slice_kind, // ascd_kind_t encoding
    input wire logic [31:0] pkt_vector_word, // fetched bit-vector word
    input wire logic [4:0] pkt_bit_sel, // bit chosen in that word
    output logic pkt_fetch // fetch selected packet
);
    logic [31:0] dw_r [1:15];
    logic [31:0] dw_nxt [1:15];
    logic [31:0] addr_r, addr_nxt, len_r, len_nxt;
    logic busy_r, busy_nxt, go_r, go_nxt;
    logic ph_act_r, ph_act_nxt, ph_wr_r, ph_wr_nxt;
    logic [7:0] ph_off_r, ph_off_nxt;
    logic [31:0] rd_r, rd_nxt;

    // working copy; latched at command start so bus writes mid-slice cannot disturb it
    logic [31:0] cmd_r [1:15];
    logic [31:0] cmd_nxt [1:15];
    logic [31:0] caddr_r, caddr_nxt, clen_r, clen_nxt;

    function automatic logic [31:0] reg_read(input logic [7:0] off, input logic [31:0] d [1:15],
                                             input logic [31:0] a, input logic [31:0] l, input logic b);
        logic [31:0] v;
        v = ascd_pkg::RST_WORD;
        if (off == ascd_pkg::OFF_STATUS) begin
            v = {31'h0000_0000, b};
        end else if (off == ascd_pkg::OFF_DW1) begin
            v = d[1];
        end else if (off >= ascd_pkg::OFF_DW3 && off <= ascd_pkg::OFF_DW15) begin
            v = d[off[7:2]];
        end else if (off == ascd_pkg::OFF_ADDR) begin
            v = a;
        end else if (off == ascd_pkg::OFF_LEN) begin
            v = l;
        end
        return v;
    endfunction : reg_read

    always_comb begin
        dw_nxt = dw_r;
        cmd_nxt = cmd_r;
        addr_nxt = addr_r;
        len_nxt = len_r;
        caddr_nxt = caddr_r;
        clen_nxt = clen_r;
        busy_nxt = busy_r;
        go_nxt = 1'b0;
        ph_act_nxt = 1'b0;
        ph_wr_nxt = 1'b0;
        ph_off_nxt = ph_off_r;
        rd_nxt = rd_r;
        if (busy_r && engine_done) begin
            busy_nxt = 1'b0;
        end
        if (ph_act_r && ph_wr_r) begin
            if (ph_off_r == ascd_pkg::OFF_CTRL) begin
                // one command per slice: a start while busy is dropped
                if (hwdata[0] && !busy_r) begin // RULE_20
                    cmd_nxt = dw_r; // RULE_24
                    caddr_nxt = addr_r;
                    clen_nxt = len_r;
                    busy_nxt = 1'b1;
                    go_nxt = 1'b1;
                end
            end else if (ph_off_r == ascd_pkg::OFF_DW1) begin
                dw_nxt[1] = hwdata;
            end else if (ph_off_r >= ascd_pkg::OFF_DW3 && ph_off_r <= ascd_pkg::OFF_DW15) begin
                dw_nxt[ph_off_r[7:2]] = hwdata;
            end else if (ph_off_r == ascd_pkg::OFF_ADDR) begin
                addr_nxt = hwdata;
            end else if (ph_off_r == ascd_pkg::OFF_LEN) begin
                len_nxt = hwdata;
            end
        end
        if (hsel && hready && htrans[1]) begin
            ph_act_nxt = 1'b1;
            ph_wr_nxt = hwrite;
            ph_off_nxt = haddr[7:0];
            if (!hwrite) begin
                rd_nxt = reg_read(haddr[7:0], dw_r, addr_r, len_r, busy_r);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 1; i <= 15; i++) begin
                dw_r[i] <= ascd_pkg::RST_WORD;
                cmd_r[i] <= ascd_pkg::RST_WORD;
            end
            addr_r <= ascd_pkg::RST_WORD;
            len_r <= ascd_pkg::RST_WORD;
            caddr_r <= ascd_pkg::RST_WORD;
            clen_r <= ascd_pkg::RST_WORD;
            busy_r <= 1'b0;
            go_r <= 1'b0;
            ph_act_r <= 1'b0;
            ph_wr_r <= 1'b0;
            ph_off_r <= 8'h00;
            rd_r <= ascd_pkg::RST_WORD;
        end else begin
            dw_r <= dw_nxt;
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            len_r <= len_nxt;
            caddr_r <= caddr_nxt;
            clen_r <= clen_nxt;
            busy_r <= busy_nxt;
            go_r <= go_nxt;
            ph_act_r <= ph_act_nxt;
            ph_wr_r <= ph_wr_nxt;
            ph_off_r <= ph_off_nxt;
            rd_r <= rd_nxt;
        end
    end

    // decoded fields, all but pkt_fetch registered from the latched command copy
    logic [31:0] d3, d4, d5, d6, d7;
    assign d3 = cmd_nxt[3];
    assign d4 = cmd_nxt[4];
    assign d5 = cmd_nxt[5];
    assign d6 = cmd_nxt[6];
    assign d7 = cmd_nxt[7];

    logic o_dir, o_ief, o_dpu, o_csu, o_skip, o_enc, o_mis, o_fetch;
    logic [1:0] o_dbk, o_ctx, o_kind;
    logic [5:0] o_qp;
    logic signed [4:0] o_beta, o_alpha;
    logic [3:0] o_fvc;
    logic [31:0] o_fbit, o_last, o_seed, o_chunk;
    logic [22:0] o_raw;

    always_comb begin
        // reserved fields are ignored throughout RULE_26
        o_kind = 2'(ascd_pkg::KIND_BAD);
        if (d3[ascd_pkg::KIND_HI:0] == ascd_pkg::KIND_P) begin // RULE_25
            o_kind = 2'(ascd_pkg::KIND_PRED);
        end else if (d3[ascd_pkg::KIND_HI:0] == ascd_pkg::KIND_B) begin
            o_kind = 2'(ascd_pkg::KIND_BIDIR);
        end else if (d3[ascd_pkg::KIND_HI:0] == ascd_pkg::KIND_I) begin
            o_kind = 2'(ascd_pkg::KIND_INTRA);
        end
        // direct type only meaningful for bidirectional slices
        o_dir = d5[ascd_pkg::DIRECT_BIT] && (o_kind == 2'(ascd_pkg::KIND_BIDIR)); // RULE_01
        o_dbk = d5[ascd_pkg::DBK_HI:ascd_pkg::DBK_LO];
        o_ief = 1'b0;
        o_dpu = 1'b0;
        o_csu = 1'b0;
        unique case (ascd_pkg::ascd_dbk_t'(o_dbk)) // RULE_02
            ascd_pkg::DBK_FILTER_ALL: begin
                o_ief = 1'b1;
                o_dpu = 1'b1;
            end
            ascd_pkg::DBK_OFF: begin
                o_ief = 1'b0;
            end
            ascd_pkg::DBK_SLICE_LOCAL: begin
                o_ief = 1'b1;
                o_dpu = 1'b1;
                o_csu = 1'b1;
            end
            ascd_pkg::DBK_RESERVED: begin
                o_ief = 1'b0;
            end
        endcase
        o_ctx = d5[ascd_pkg::CTX_HI:ascd_pkg::CTX_LO]; // RULE_03
        o_qp = d5[ascd_pkg::QP_HI:ascd_pkg::QP_LO]; // RULE_04
        o_beta = {d5[ascd_pkg::BETA_HI], d5[ascd_pkg::BETA_HI:ascd_pkg::BETA_LO]}; // RULE_05
        o_alpha = {d5[ascd_pkg::ALPHA_HI], d5[ascd_pkg::ALPHA_HI:ascd_pkg::ALPHA_LO]}; // RULE_06
        o_skip = d7[ascd_pkg::SKIP_BIT]; // RULE_10
        o_fvc = {1'b0, d7[ascd_pkg::FBV_HI:0]} + 4'h1; // RULE_11
        // valid bits are the low bits of the first byte; first used bit is the highest valid one
        o_fbit = {caddr_nxt[28:0], 3'h0} + {29'h0, d7[ascd_pkg::FBV_HI:0]}; // RULE_21
        o_last = caddr_nxt + clen_nxt - 32'h1; // RULE_22
        o_enc = cmd_nxt[1][ascd_pkg::ENC_BIT]; // RULE_23
        o_seed = o_enc ? cmd_nxt[8] : ascd_pkg::RST_WORD; // RULE_13
        o_chunk = {caddr_nxt[31:4], 4'h0};
        o_raw = cmd_nxt[9][ascd_pkg::RAWLEN_HI:0] - 23'h1; // RULE_14
        o_mis = cmd_nxt[11][ascd_pkg::PAGE_BITS-1:0] != 12'h000; // RULE_17
        o_fetch = !pkt_vector_word[pkt_bit_sel]; // RULE_18
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            direct_spatial <= 1'b0;
            deblock_control <= 2'h0;
            internal_edge_filter_flag <= 1'b0;
            deblock_params_used <= 1'b0;
            cross_slice_unavail <= 1'b0;
            arith_ctx_table_index <= 2'h0;
            slice_quantizer <= 6'h00;
            beta_strength_offset <= 5'sh00;
            alpha_strength_offset <= 5'sh00;
            start_row <= 8'h00;
            start_column <= 8'h00;
            start_block_index <= 15'h0000;
            alt_skip_decode <= 1'b0;
            first_valid_count <= 4'h0;
            first_bit_addr <= ascd_pkg::RST_WORD;
            last_byte_addr <= ascd_pkg::RST_WORD;
            decrypt_enable <= 1'b0;
            aes_counter_seed <= ascd_pkg::RST_WORD;
            aes_chunk_addr <= ascd_pkg::RST_WORD;
            raw_length <= 23'h000000;
            vector_start_bit <= 3'h0;
            packet_count <= 16'h0000;
            vector_addr <= 29'h00000000;
            vector_misaligned <= 1'b0;
            unity_weight_mask_y_list0 <= ascd_pkg::RST_WORD;
            unity_weight_mask_y_list1 <= ascd_pkg::RST_WORD;
            unity_weight_mask_c_list0 <= ascd_pkg::RST_WORD;
            unity_weight_mask_c_list1 <= ascd_pkg::RST_WORD;
            slice_kind <= 2'h0;
            pkt_fetch <= 1'b0;
            slice_go <= 1'b0;
            hrdata <= ascd_pkg::RST_WORD;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            direct_spatial <= o_dir;
            deblock_control <= o_dbk;
            internal_edge_filter_flag <= o_ief;
            deblock_params_used <= o_dpu;
            cross_slice_unavail <= o_csu;
            arith_ctx_table_index <= o_ctx;
            slice_quantizer <= o_qp;
            beta_strength_offset <= o_beta;
            alpha_strength_offset <= o_alpha;
            start_row <= d6[ascd_pkg::ROW_HI:ascd_pkg::ROW_LO]; // RULE_07
            start_column <= d6[ascd_pkg::COL_HI:ascd_pkg::COL_LO]; // RULE_07
            start_block_index <= d6[ascd_pkg::IDX_HI:0];
            alt_skip_decode <= o_skip;
            first_valid_count <= o_fvc;
            first_bit_addr <= o_fbit;
            last_byte_addr <= o_last;
            decrypt_enable <= o_enc;
            aes_counter_seed <= o_seed;
            aes_chunk_addr <= o_chunk;
            raw_length <= o_raw;
            vector_start_bit <= cmd_nxt[10][ascd_pkg::VSTART_HI:ascd_pkg::VSTART_LO]; // RULE_16
            packet_count <= cmd_nxt[10][ascd_pkg::PKTCNT_HI:0]; // RULE_16
            vector_addr <= cmd_nxt[11][ascd_pkg::VADDR_HI:0]; // RULE_17
            vector_misaligned <= o_mis;
            unity_weight_mask_y_list0 <= cmd_nxt[12]; // RULE_19
            unity_weight_mask_y_list1 <= cmd_nxt[13];
            unity_weight_mask_c_list0 <= cmd_nxt[14];
            unity_weight_mask_c_list1 <= cmd_nxt[15];
            slice_kind <= o_kind;
            pkt_fetch <= o_fetch;
            slice_go <= go_nxt;
            hrdata <= rd_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule : ascd_slice_decode

// ---- verification/ascd_engine_model.sv ----
`timescale 1ns/1ns
module ascd_engine_model (
    input wire logic core_clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic slice_go, // start pulse from decoder
    input wire logic [7:0] delay, // cycles spent on one slice
    output logic engine_done // one-cycle finish pulse
);
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic done_nxt;
    // one finish per start: a slice is one command
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (slice_go) begin
            cnt_nxt = {1'b0, delay} + 9'h1;
        end else if (cnt_r != 9'h0) begin
            cnt_nxt = cnt_r - 9'h1;
            done_nxt = (cnt_r == 9'h1);
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 9'h0;
            engine_done <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            engine_done <= done_nxt;
        end
    end
endmodule : ascd_engine_model

// ---- verification/ascd_slice_decode_assertions.sv ----
`timescale 1ns/1ns
module ascd_slice_decode_assertions (
    input wire logic core_clk, // clock
    input wire logic nrst, // reset
    input wire logic slice_go, // start pulse
    input wire logic direct_spatial, // direct type
    input wire logic [1:0] deblock_control, // deblock mode
    input wire logic internal_edge_filter_flag, // edge filter
    input wire logic deblock_params_used, // params read
    input wire logic cross_slice_unavail, // slice local
    input wire logic [5:0] slice_quantizer, // qp
    input wire logic [14:0] start_block_index, // first mb
    input wire logic [3:0] first_valid_count, // valid bits
    input wire logic decrypt_enable, // decrypt on
    input wire logic [31:0] aes_counter_seed, // counter
    input wire logic [28:0] vector_addr, // vector base
    input wire logic vector_misaligned, // page flag
    input wire logic [1:0] slice_kind, // kind
    input wire logic [31:0] pkt_vector_word, // vector word
    input wire logic [4:0] pkt_bit_sel, // bit select
    input wire logic pkt_fetch // fetch decision
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    chk_edge_flag: assert property (slice_go |-> internal_edge_filter_flag == (deblock_control inside {2'h0, 2'h2}))
        else $error("edge filter flag wrong");
    chk_cross_slice: assert property (slice_go |-> cross_slice_unavail == (deblock_control == 2'h2))
        else $error("cross slice flag wrong");
    chk_dbk_params: assert property (slice_go |-> deblock_params_used == internal_edge_filter_flag)
        else $error("deblock params flag wrong");
    chk_direct_kind: assert property (slice_go && slice_kind != 2'h1 |-> !direct_spatial)
        else $error("spatial direct on non-bidir slice");
    chk_valid_count: assert property (slice_go |-> first_valid_count inside {[4'h1:4'h8]})
        else $error("valid bit count out of range");
    chk_seed_plain: assert property (slice_go && !decrypt_enable |-> aes_counter_seed == 32'h0)
        else $error("counter seed used when plain");
    chk_vec_page: assert property (slice_go |-> vector_misaligned == (vector_addr[11:0] != 12'h0))
        else $error("page flag wrong");
    chk_pkt_fetch: assert property ($past(nrst) && $stable(pkt_vector_word) && $stable(pkt_bit_sel)
        |-> pkt_fetch == !pkt_vector_word[pkt_bit_sel]) else $error("fetch decision wrong");
    chk_go_pulse: assert property (slice_go |=> !slice_go)
        else $error("start pulse too long");
    chk_params_hold: assert property (!slice_go |-> $stable(slice_quantizer) && $stable(start_block_index))
        else $error("parameters changed without command");
    cover property (slice_go && decrypt_enable);
    cover property (slice_go && deblock_control == 2'h2);
    cover property (pkt_fetch);
endmodule : ascd_slice_decode_assertions

bind ascd_slice_decode ascd_slice_decode_assertions ascd_slice_decode_assertions_inst (.*);

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin $display("ERROR %s exp %0h got %0h", nm, e, s); num_errors++; end end
module testbench;
    logic core_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, engine_done, slice_go, direct_spatial;
    logic internal_edge_filter_flag, deblock_params_used, cross_slice_unavail, alt_skip_decode, decrypt_enable;
    logic vector_misaligned, pkt_fetch;
    logic [31:0] haddr, hwdata, hrdata, first_bit_addr, last_byte_addr, aes_counter_seed, aes_chunk_addr;
    logic [31:0] unity_weight_mask_y_list0, unity_weight_mask_y_list1, unity_weight_mask_c_list0;
    logic [31:0] unity_weight_mask_c_list1, pkt_vector_word;
    logic [31:0] cfg [18];
    logic [1:0] htrans, deblock_control, arith_ctx_table_index, slice_kind;
    logic [2:0] hsize, vector_start_bit;
    logic [5:0] slice_quantizer;
    logic signed [4:0] beta_strength_offset, alpha_strength_offset;
    logic [7:0] start_row, start_column, eng_delay;
    logic [14:0] start_block_index;
    logic [3:0] first_valid_count;
    logic [22:0] raw_length;
    logic [15:0] packet_count;
    logic [28:0] vector_addr;
    logic [4:0] pkt_bit_sel;
    int num_errors = 0;
    int samples_checked = 0;
    assign hready = hreadyout;
    ascd_slice_decode ascd_slice_decode_inst (.*);
    ascd_engine_model ascd_engine_model_inst (.core_clk(core_clk), .nrst(nrst), .slice_go(slice_go),
        .delay(eng_delay), .engine_done(engine_done));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task print_verdict;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // one single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 40);
        q = hrdata;
        if (n >= 40) begin
            num_errors++;
            print_verdict();
        end
    endtask : ahb
    task automatic go;
        logic [31:0] q;
        int n;
        n = 0;
        do begin ahb(1'b0, ascd_pkg::OFF_STATUS, 32'h0, q); n++; end while (q[0] !== 1'b0 && n < 60);
        if (q[0] !== 1'b0) begin
            num_errors++;
            print_verdict();
        end
        for (int i = 2; i < 18; i++) ahb(1'b1, 8'(i * 4), cfg[i], q);
        ahb(1'b1, ascd_pkg::OFF_CTRL, 32'h1, q);
        n = 0;
        while (slice_go !== 1'b1 && n < 8) begin @(posedge core_clk); n++; end
        `CHK("slice_go", 1'b1, slice_go)
    endtask : go
    task automatic t_reset;
        logic [31:0] q;
        `CHK("hreadyout", 1'b1, hreadyout)
        `CHK("hresp", 1'b0, hresp)
        `CHK("qp", 6'h0, slice_quantizer)
        ahb(1'b0, 8'h80, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
    endtask : t_reset
    task automatic t_deblock;
        logic [1:0] dd;
        logic [5:0] qp;
        for (int d = 0; d < 4; d++) begin
            dd = 2'(d);
            qp = 6'h20 + 6'(d);
            foreach (cfg[i]) cfg[i] = 32'h0;
            cfg[3] = {28'h0, ascd_pkg::KIND_B};
            cfg[5] = {2'h0, 1'b1, dd, 1'b0, dd, 2'h0, qp, 16'h0a06};
            go();
            `CHK("direct", 1'b1, direct_spatial)
            `CHK("dbk", dd, deblock_control)
            `CHK("edge", dd == 2'h0 || dd == 2'h2, internal_edge_filter_flag)
            `CHK("unavail", dd == 2'h2, cross_slice_unavail)
            `CHK("params", dd == 2'h0 || dd == 2'h2, deblock_params_used)
            `CHK("ctx", dd, arith_ctx_table_index)
            `CHK("qp", qp, slice_quantizer)
            `CHK("beta", 5'h1a, beta_strength_offset)
            `CHK("alpha", 5'h06, alpha_strength_offset)
            `CHK("kind", 2'h1, slice_kind)
        end
    endtask : t_deblock
    task automatic t_plain;
        foreach (cfg[i]) cfg[i] = 32'h0;
        cfg[5] = 32'h2000_0000;
        cfg[6] = 32'h1234_08a4;
        cfg[7] = 32'h0000_0080;
        cfg[8] = 32'hdead_beef;
        cfg[16] = 32'h0000_1235;
        cfg[17] = 32'h0000_0040;
        go();
        `CHK("direct", 1'b0, direct_spatial)
        `CHK("row", 8'h12, start_row)
        `CHK("col", 8'h34, start_column)
        `CHK("index", 15'h08a4, start_block_index)
        `CHK("skip", 1'b1, alt_skip_decode)
        `CHK("valid", 4'h1, first_valid_count)
        `CHK("firstbit", 32'h0000_91a8, first_bit_addr)
        `CHK("lastbyte", 32'h0000_1274, last_byte_addr)
        `CHK("decrypt", 1'b0, decrypt_enable)
        `CHK("seed", 32'h0, aes_counter_seed)
        `CHK("kind", 2'h0, slice_kind)
    endtask : t_plain
    task automatic t_crypt;
        foreach (cfg[i]) cfg[i] = 32'h0;
        cfg[2] = 32'h8000_0000;
        cfg[3] = {28'h0, ascd_pkg::KIND_I};
        cfg[7] = 32'h0000_0007;
        cfg[8] = 32'h1357_9bdf;
        cfg[9] = 32'h0000_0101;
        cfg[10] = 32'ha000_00c8;
        cfg[11] = 32'h0000_3010;
        for (int k = 12; k < 16; k++) cfg[k] = 32'h8000_0001 << (k - 12);
        cfg[16] = 32'h0000_1237;
        go();
        `CHK("decrypt", 1'b1, decrypt_enable)
        `CHK("seed", 32'h1357_9bdf, aes_counter_seed)
        `CHK("chunk", 32'h0000_1230, aes_chunk_addr)
        `CHK("valid", 4'h8, first_valid_count)
        `CHK("rawlen", 23'h100, raw_length)
        `CHK("vstart", 3'h5, vector_start_bit)
        `CHK("pkts", 16'h00c8, packet_count)
        `CHK("vaddr", 29'h3010, vector_addr)
        `CHK("misalign", 1'b1, vector_misaligned)
        `CHK("y0", 32'h8000_0001, unity_weight_mask_y_list0)
        `CHK("y1", 32'h0000_0002, unity_weight_mask_y_list1)
        `CHK("c0", 32'h0000_0004, unity_weight_mask_c_list0)
        `CHK("c1", 32'h0000_0008, unity_weight_mask_c_list1)
        `CHK("kind", 2'h2, slice_kind)
    endtask : t_crypt
    // a start while the engine is still busy must be dropped
    task automatic t_busy;
        logic [31:0] q;
        int seen;
        seen = 0;
        eng_delay <= 8'd60;
        cfg[5] = 32'h0011_0000;
        cfg[6] = 32'h0000_1fe1;
        go();
        `CHK("phantom", 15'h1fe1, start_block_index)
        ahb(1'b0, ascd_pkg::OFF_STATUS, 32'h0, q);
        `CHK("busy", 1'b1, q[0])
        ahb(1'b1, ascd_pkg::OFF_DW5, 32'h0022_0000, q);
        ahb(1'b1, ascd_pkg::OFF_CTRL, 32'h1, q);
        repeat (6) begin @(posedge core_clk); if (slice_go === 1'b1) seen++; end
        `CHK("refused", 0, seen)
        `CHK("qp", 6'h11, slice_quantizer)
        eng_delay <= 8'd1;
    endtask : t_busy
    task automatic t_pkt;
        for (int s = 0; s < 32; s++) begin
            pkt_vector_word <= 32'ha5c3_0f96;
            pkt_bit_sel <= 5'(s);
            repeat (2) @(posedge core_clk);
            `CHK("fetch", ~pkt_vector_word[s], pkt_fetch)
        end
    endtask : t_pkt
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pkt_vector_word = 32'h0;
        pkt_bit_sel = 5'h0;
        eng_delay = 8'd1;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_deblock();
        t_plain();
        t_crypt();
        t_busy();
        t_pkt();
        print_verdict();
    end
endmodule : testbench
